// ===== bcfg_regs.vh
// offsets, field positions, reset values and rule summary for the boot configuration bank
// What this block does
// - The bridge map field resets to one and is held at one whatever software writes.
// - Dynamic alias high with static alias low maps dynamic memory at address zero.
// - Both alias enables high map expansion memory at address zero when both boot chip-select lines are high, static memory otherwise.
// - Static alias high with dynamic alias low maps static memory at address zero.
// - The dynamic alias enable resets to zero and software writes never change it.
// - Expansion memory is only aliased when both boot chip-select lines are high.
// - The memory controller select resets to zero and is kept at zero.
// - The coprocessor enable resets to one and drives the coprocessor multiplexer enable.
// - The endian init bit resets to zero; low is little-endian, high is big-endian.
// - The vector bit resets to zero; low puts vectors at zero, high at the high address.
`ifndef BCFG_REGS_VH
`define BCFG_REGS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BCFG_ADDR_W 4
`define BCFG_OFS_CFG 4'h0
`define BCFG_OFS_STAT 4'h4

// ----------------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------------
`define BCFG_BIT_VEC 0
`define BCFG_BIT_END 1
`define BCFG_BIT_FPU 2
`define BCFG_BIT_MCS 3
`define BCFG_BIT_SAL 4
`define BCFG_BIT_DAL 5
`define BCFG_BIT_BRG 6

// ----------------------------------------------------------------------
// configuration reset values
// ----------------------------------------------------------------------
`define BCFG_RST_VEC 1'b0
`define BCFG_RST_END 1'b0
`define BCFG_RST_FPU 1'b1
`define BCFG_RST_MCS 1'b0
`define BCFG_RST_SAL 1'b1
`define BCFG_RST_DAL 1'b0
`define BCFG_RST_BRG 1'b1

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define BCFG_ERR_N 4
`define BCFG_ERR_BRG 0
`define BCFG_ERR_MCS 1
`define BCFG_ERR_ALIAS 2
`define BCFG_ERR_EXP 3
`define BCFG_STAT_MAP_LSB 4
`define BCFG_STAT_MAP_MSB 7

// ----------------------------------------------------------------------
// address zero map codes (one-hot, none when all low)
// ----------------------------------------------------------------------
`define BCFG_MAP_W 3
`define BCFG_MAP_NONE 3'h0
`define BCFG_MAP_DYN 3'h1
`define BCFG_MAP_STA 3'h2
`define BCFG_MAP_EXP 3'h4

// ----------------------------------------------------------------------
// exception vector bases
// ----------------------------------------------------------------------
`define BCFG_VEC_LOW 32'h00000000
`define BCFG_VEC_HIGH 32'hffff0000

`endif

// ===== bcfg_alias_dec.v
// address zero alias decode with registered outputs
`timescale 1ns/1ns
`include "bcfg_regs.vh"

module bcfg_alias_dec (
    input wire clk,
    input wire srst,
    input wire dyn_alias_en,
    input wire static_alias_en,
    input wire [1:0] boot_cs_select,
    output reg [2:0] alias_map_q,
    output reg exp_blocked_q
);

// ----------------------------------------------------------------------
// decode
// ----------------------------------------------------------------------
reg [2:0] alias_map_d;
reg exp_blocked_d;
wire cs_allows_exp;

assign cs_allows_exp = &boot_cs_select;

always @* begin
    alias_map_d = `BCFG_MAP_NONE;
    exp_blocked_d = 1'b0;
    case ({dyn_alias_en, static_alias_en})
        2'b10: begin
            alias_map_d = `BCFG_MAP_DYN;
        end
        2'b01: begin
            alias_map_d = `BCFG_MAP_STA;
        end
        2'b11: begin
            if (cs_allows_exp) begin
                alias_map_d = `BCFG_MAP_EXP;
            end else begin
                // boot select forbids expansion; keep static memory at zero
                alias_map_d = `BCFG_MAP_STA;
                exp_blocked_d = 1'b1;
            end
        end
        default: begin
            alias_map_d = `BCFG_MAP_NONE;
        end
    endcase
end

// ----------------------------------------------------------------------
// output flops
// ----------------------------------------------------------------------
always @(posedge clk) begin
    if (srst) begin
        alias_map_q <= `BCFG_MAP_STA;
        exp_blocked_q <= 1'b0;
    end else begin
        alias_map_q <= alias_map_d;
        exp_blocked_q <= exp_blocked_d;
    end
end

endmodule // bcfg_alias_dec

// ===== bcfg_boot_cfg.v
// boot configuration register bank, low seven bits
`timescale 1ns/1ns
`include "bcfg_regs.vh"

module bcfg_boot_cfg #(
    parameter ADDR_W = `BCFG_ADDR_W
) (
    input wire clk,
    input wire srst,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [1:0] boot_cs_select,
    input wire dyn_alias_strap,
    output wire bridge_map_sel,
    output wire dyn_alias_en,
    output wire static_alias_en,
    output wire memctl_select,
    output wire fp_coproc_en,
    output wire endian_init,
    output wire vector_high_sel,
    output reg [31:0] vector_base_q,
    output wire [2:0] alias_map
);

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
reg [1:0] cs_meta_q;
reg [1:0] cs_sync_q;
reg strap_meta_q;
reg strap_sync_q;

always @(posedge clk) begin
    if (srst) begin
        cs_meta_q <= 2'h0;
        cs_sync_q <= 2'h0;
        strap_meta_q <= 1'b0;
        strap_sync_q <= 1'b0;
    end else begin
        cs_meta_q <= boot_cs_select;
        cs_sync_q <= cs_meta_q;
        strap_meta_q <= dyn_alias_strap;
        strap_sync_q <= strap_meta_q;
    end
end

// ----------------------------------------------------------------------
// decode of the register port
// ----------------------------------------------------------------------
wire hit_cfg;
wire hit_stat;
wire wr_cfg;
wire wr_stat;

assign hit_cfg = (reg_addr == `BCFG_OFS_CFG);
assign hit_stat = (reg_addr == `BCFG_OFS_STAT);
assign wr_cfg = reg_wr & hit_cfg;
assign wr_stat = reg_wr & hit_stat;

// ----------------------------------------------------------------------
// configuration flops
// ----------------------------------------------------------------------
reg brg_q;
reg dal_q;
reg sal_q;
reg mcs_q;
reg fpu_q;
reg end_q;
reg vec_q;
reg sal_d;
reg dal_d;
reg alias_refused;
wire brg_viol;
wire mcs_viol;

// a write of zero to the bridge field is refused and recorded
assign brg_viol = wr_cfg & ~reg_wdata[`BCFG_BIT_BRG];
// a write of one to the controller select is refused and recorded
assign mcs_viol = wr_cfg & reg_wdata[`BCFG_BIT_MCS];

always @* begin
    // read-only to software: follows the synchronised strap in every cycle
    dal_d = strap_sync_q;
    sal_d = sal_q;
    alias_refused = 1'b0;
    if (wr_cfg) begin
        if (!reg_wdata[`BCFG_BIT_SAL] && !dal_d) begin
            // both enables low is unsupported; keep the old static enable
            alias_refused = 1'b1;
        end else begin
            sal_d = reg_wdata[`BCFG_BIT_SAL];
        end
    end
    if (!sal_d && !dal_d) begin
        // strap dropped while static was off: restore static alias
        sal_d = 1'b1;
    end
end

always @(posedge clk) begin
    if (srst) begin
        brg_q <= `BCFG_RST_BRG;
        dal_q <= `BCFG_RST_DAL;
        sal_q <= `BCFG_RST_SAL;
        mcs_q <= `BCFG_RST_MCS;
        fpu_q <= `BCFG_RST_FPU;
        end_q <= `BCFG_RST_END;
        vec_q <= `BCFG_RST_VEC;
    end else begin
        brg_q <= 1'b1;
        dal_q <= dal_d;
        sal_q <= sal_d;
        mcs_q <= 1'b0;
        if (wr_cfg) begin
            fpu_q <= reg_wdata[`BCFG_BIT_FPU];
            end_q <= reg_wdata[`BCFG_BIT_END];
            vec_q <= reg_wdata[`BCFG_BIT_VEC];
        end
    end
end

// ----------------------------------------------------------------------
// vector base
// ----------------------------------------------------------------------
always @(posedge clk) begin
    if (srst) begin
        vector_base_q <= `BCFG_VEC_LOW;
    end else if (wr_cfg && reg_wdata[`BCFG_BIT_VEC]) begin
        vector_base_q <= `BCFG_VEC_HIGH;
    end else if (wr_cfg) begin
        vector_base_q <= `BCFG_VEC_LOW;
    end
end

// ----------------------------------------------------------------------
// consumer outputs straight from the flops
// ----------------------------------------------------------------------
assign bridge_map_sel = brg_q;
assign dyn_alias_en = dal_q;
assign static_alias_en = sal_q;
assign memctl_select = mcs_q;
assign fp_coproc_en = fpu_q;
assign endian_init = end_q;
assign vector_high_sel = vec_q;

// ----------------------------------------------------------------------
// address zero alias
// ----------------------------------------------------------------------
wire exp_blocked;

bcfg_alias_dec u_alias (
    .clk(clk),
    .srst(srst),
    .dyn_alias_en(dal_q),
    .static_alias_en(sal_q),
    .boot_cs_select(cs_sync_q),
    .alias_map_q(alias_map),
    .exp_blocked_q(exp_blocked)
);

// ----------------------------------------------------------------------
// sticky error flags, write one to clear, set wins
// ----------------------------------------------------------------------
reg [`BCFG_ERR_N-1:0] err_q;
wire [`BCFG_ERR_N-1:0] err_set;

assign err_set[`BCFG_ERR_BRG] = brg_viol;
assign err_set[`BCFG_ERR_MCS] = mcs_viol;
assign err_set[`BCFG_ERR_ALIAS] = alias_refused;
assign err_set[`BCFG_ERR_EXP] = exp_blocked;

genvar gi;
generate
    for (gi = 0; gi < `BCFG_ERR_N; gi = gi + 1) begin : g_err
        always @(posedge clk) begin
            if (srst) begin
                err_q[gi] <= 1'b0;
            end else if (err_set[gi]) begin
                err_q[gi] <= 1'b1;
            end else if (wr_stat && reg_wdata[gi]) begin
                err_q[gi] <= 1'b0;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------------
// read data, valid only in the cycle after the strobe
// ----------------------------------------------------------------------
reg [31:0] rdata_d;

always @* begin
    rdata_d = 32'h00000000;
    if (reg_rd && hit_cfg) begin
        rdata_d[`BCFG_BIT_BRG] = brg_q;
        rdata_d[`BCFG_BIT_DAL] = dal_q;
        rdata_d[`BCFG_BIT_SAL] = sal_q;
        rdata_d[`BCFG_BIT_MCS] = mcs_q;
        rdata_d[`BCFG_BIT_FPU] = fpu_q;
        rdata_d[`BCFG_BIT_END] = end_q;
        rdata_d[`BCFG_BIT_VEC] = vec_q;
    end else if (reg_rd && hit_stat) begin
        rdata_d[`BCFG_ERR_N-1:0] = err_q;
        rdata_d[`BCFG_STAT_MAP_MSB-1:`BCFG_STAT_MAP_LSB] = alias_map;
    end
end

always @(posedge clk) begin
    if (srst) begin
        reg_rdata <= 32'h00000000;
    end else begin
        reg_rdata <= rdata_d;
    end
end

endmodule // bcfg_boot_cfg

// ===== bcfg_boot_cfg_checker.sv
// assertions on the boot configuration bank ports
`timescale 1ns/1ns
module bcfg_boot_cfg_checker (
    input wire clk,
    input wire srst,
    input wire [1:0] boot_cs_select,
    input wire dyn_alias_strap,
    input wire bridge_map_sel,
    input wire dyn_alias_en,
    input wire static_alias_en,
    input wire memctl_select,
    input wire fp_coproc_en,
    input wire endian_init,
    input wire vector_high_sel,
    input wire [31:0] vector_base_q,
    input wire [2:0] alias_map
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence dyn_only_s;
        dyn_alias_en && !static_alias_en;
    endsequence
    sequence sta_only_s;
        static_alias_en && !dyn_alias_en;
    endsequence
    sequence exp_req_s;
        (dyn_alias_en && static_alias_en && boot_cs_select == 2'b11) [*5];
    endsequence
    sequence cs_off_s;
        (boot_cs_select != 2'b11) [*5];
    endsequence
    bridge_fixed_a: assert property (bridge_map_sel)
        else $error("bridge map select low");
    memctl_fixed_a: assert property (!memctl_select)
        else $error("memory controller select high");
    dyn_map_a: assert property (dyn_only_s |=> alias_map == 3'h1)
        else $error("dynamic memory not at zero");
    exp_map_a: assert property (exp_req_s |=> alias_map == 3'h4)
        else $error("expansion memory not at zero");
    sta_map_a: assert property (sta_only_s |=> alias_map == 3'h2)
        else $error("static memory not at zero");
    exp_gate_a: assert property (cs_off_s |-> alias_map != 3'h4)
        else $error("expansion mapped without boot select");
    dyn_ro_a: assert property ((!dyn_alias_strap) [*4] |-> !dyn_alias_en)
        else $error("dynamic alias enable moved");
    reset_val_a: assert property ($fell(srst) |->
        fp_coproc_en && !endian_init && !vector_high_sel && !dyn_alias_en)
        else $error("wrong value after reset");
    vec_base_a: assert property (vector_base_q ==
        (vector_high_sel ? 32'hffff0000 : 32'h00000000))
        else $error("vector base mismatch");
endmodule // bcfg_boot_cfg_checker

bind bcfg_boot_cfg bcfg_boot_cfg_checker bcfg_boot_cfg_checker_i (.clk(clk), .srst(srst),
    .boot_cs_select(boot_cs_select), .dyn_alias_strap(dyn_alias_strap),
    .bridge_map_sel(bridge_map_sel), .dyn_alias_en(dyn_alias_en),
    .static_alias_en(static_alias_en), .memctl_select(memctl_select),
    .fp_coproc_en(fp_coproc_en), .endian_init(endian_init),
    .vector_high_sel(vector_high_sel), .vector_base_q(vector_base_q),
    .alias_map(alias_map));

// ===== bcfg_core_model.sv
// processor core model that takes its reset settings from the bank
`timescale 1ns/1ns
module bcfg_core_model (
    input wire logic clk,
    input wire logic core_rst,
    input wire logic endian_init,
    input wire logic vector_high_sel,
    input wire logic fp_coproc_en,
    input wire logic memctl_select,
    input wire logic dyn_alias_en,
    input wire logic static_alias_en,
    output logic [31:0] vec_base,
    output logic big,
    output logic fp_on,
    output logic bad
);
    // vector base and endianness are only taken while the core is held in reset; the coprocessor enable is followed at all times
    always @(posedge clk) begin
        if (core_rst) begin
            vec_base <= vector_high_sel ? 32'hffff0000 : 32'h00000000;
            big <= endian_init;
        end
    end
    assign fp_on = fp_coproc_en;
    assign bad = memctl_select | ~(dyn_alias_en | static_alias_en);
endmodule // bcfg_core_model

// ===== bcfg_boot_cfg_test.sv
// self-checking bench for the boot configuration bank
`timescale 1ns/1ns
module bcfg_boot_cfg_test;
    logic clk, srst, reg_wr, reg_rd, strap, core_rst;
    logic brg, dyn, sal, mcs, fpu, endi, vhi, cbig, cfp, cbad;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, vbase, cvec, rd_v, seed;
    logic [1:0] cs;
    logic [2:0] amap;
    int errors, compares, m_cfg, m_dyn;
    bcfg_boot_cfg bcfg_boot_cfg_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .boot_cs_select(cs), .dyn_alias_strap(strap), .bridge_map_sel(brg),
        .dyn_alias_en(dyn), .static_alias_en(sal), .memctl_select(mcs),
        .fp_coproc_en(fpu), .endian_init(endi), .vector_high_sel(vhi),
        .vector_base_q(vbase), .alias_map(amap));
    bcfg_core_model bcfg_core_model_i (.clk(clk), .core_rst(core_rst), .endian_init(endi),
        .vector_high_sel(vhi), .fp_coproc_en(fpu), .memctl_select(mcs),
        .dyn_alias_en(dyn), .static_alias_en(sal), .vec_base(cvec), .big(cbig),
        .fp_on(cfp), .bad(cbad));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        reg_wdata <= rnd();
        // model: bridge forced one, memctl zero, static kept while dynamic is off
        if (a == 4'h0)
            m_cfg = 32'h40 | (d & 7) | ((d[4] || !m_dyn) ? 32'h10 : 0) | (m_dyn ? 32'h20 : 0);
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 rd_v = reg_rdata;
    endtask
    task cfg_chk;
        rd(4'h0);
        chk(rd_v, m_cfg, "config");
        chk({brg, dyn, sal, mcs, fpu, endi, vhi}, m_cfg[6:0], "pins");
        chk(vbase, m_cfg[0] ? 32'hffff0000 : 0, "vector base");
        chk(cbad, 0, "core sees bad setting");
    endtask
    initial begin
        seed = 32'hb17e4754;
        srst = 1;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 4'h0;
        reg_wdata = 32'h00000000;
        strap = 0;
        core_rst = 0;
        cs = 2'b11;
        errors = 0;
        compares = 0;
        m_cfg = 32'h54;
        m_dyn = 0;
        repeat (3) @(posedge clk);
        srst <= 0;
        cfg_chk();
        chk(amap, 3'h2, "static map");
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, (rnd() & 32'hffffffa0) | 32'h50 | i);
            @(posedge clk) core_rst <= 1;
            @(posedge clk) core_rst <= 0;
            #1 chk(cvec, i[0] ? 32'hffff0000 : 0, "core vector");
            chk(cbig, i[1], "core endian");
            chk(cfp, i[2], "core coprocessor");
            cfg_chk();
        end
        wr(4'h0, 32'h08);
        cfg_chk();
        rd(4'h4);
        chk(rd_v, 32'h27, "refusal status");
        wr(4'h4, 32'h0f);
        strap <= 1;
        m_dyn = 1;
        m_cfg = m_cfg | 32'h20;
        repeat (4) @(posedge clk);
        wr(4'h0, 32'h64);
        @(posedge clk);
        #1 chk(amap, 3'h1, "dynamic map");
        cfg_chk();
        for (int c = 0; c < 4; c++) begin
            cs <= c[1:0];
            wr(4'h0, 32'h55);
            repeat (4) @(posedge clk);
            #1 chk(amap, c == 3 ? 3'h4 : 3'h2, "alias map");
        end
        strap <= 0;
        m_dyn = 0;
        m_cfg = (m_cfg & ~32'h20) | 32'h10;
        repeat (6) @(posedge clk);
        cfg_chk();
        chk(amap, 3'h2, "static again");
        wr(4'h8, rnd());
        rd(4'h8);
        chk(rd_v, 0, "unmapped");
        cfg_chk();
        stop_test();
    end
    initial begin
        #20000;
        errors++;
        stop_test();
    end
endmodule // bcfg_boot_cfg_test
